// ### logic/php_pkg.sv
// Purpose: constants for the host-side parallel register port controller
// Assumes: 10 MHz system clock, 8-bit device data bus
// Notes:   strobe phase lengths are whole clock cycles
package php_pkg;
  localparam int unsigned CLK_HZ         = 10_000_000;
  localparam int unsigned DATA_W         = 8;
  localparam int unsigned ADDR_W         = 8;
  // strobe low time and setup/hold, in ns
  localparam int unsigned T_SETUP_NS     = 100;
  localparam int unsigned T_STROBE_NS    = 300;
  localparam int unsigned T_HOLD_NS      = 100;
  localparam int unsigned NS_PER_S       = 1_000_000_000;
  localparam int unsigned SETUP_CYC_I    = (T_SETUP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned STROBE_CYC_I   = (T_STROBE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned HOLD_CYC_I     = (T_HOLD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [3:0]  SETUP_CYC      = 4'(SETUP_CYC_I < 1 ? 1 : SETUP_CYC_I);
  localparam logic [3:0]  STROBE_CYC     = 4'(STROBE_CYC_I < 1 ? 1 : STROBE_CYC_I);
  localparam logic [3:0]  HOLD_CYC       = 4'(HOLD_CYC_I < 1 ? 1 : HOLD_CYC_I);
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RST = 8'h00;

  typedef enum logic [4:0] {
    ST_IDLE   = 5'b0_0001,
    ST_SETUP  = 5'b0_0010,
    ST_STROBE = 5'b0_0100,
    ST_HOLD   = 5'b0_1000,
    ST_DONE   = 5'b1_0000
  } php_state_t;
endpackage : php_pkg

// ### logic/php_host.sv
// Purpose: host controller driving the device's parallel register port pins
// Assumes: one request at a time; i_req is taken only while o_ready is high
// Notes:   address pins leave the host through o_addr
//          chip enable is held low through the whole access; the strobes alone frame it
//          a request is acted on only while o_ready is high; one raised mid-access is dropped
//
// Operation
// - write strobe and chip enable both low loads data into addressed register
// - chip enable may stay low or move together with the write strobe
// - read strobe and chip enable both low present the addressed register
// - chip enable may move together with the read strobe on reads
// - chip enable active low; strobes ignored while it is high
`timescale 1ns/100ps
`default_nettype none
module php_host (
  input  wire logic                        i_clk,
  input  wire logic                        i_resetn,
  input  wire logic                        i_req,
  input  wire logic                        i_we,
  input  wire logic [php_pkg::ADDR_W-1:0]  i_addr,
  input  wire logic [php_pkg::DATA_W-1:0]  i_wdata,
  output logic                             o_ready,
  output logic                             o_done,
  output logic [php_pkg::DATA_W-1:0]       o_rdata,
  output logic [php_pkg::ADDR_W-1:0]       o_addr,
  output logic                             o_ce_n,
  output logic                             o_wr_n,
  output logic                             o_rd_n,
  input  wire logic [php_pkg::DATA_W-1:0]  i_host_data_bus,
  output logic [php_pkg::DATA_W-1:0]       o_host_data_bus,
  output logic                             o_host_data_bus_oe
);
  php_pkg::php_state_t          state_r, state_nxt;
  logic [3:0]                   cnt_r, cnt_nxt;
  logic                         we_r, we_nxt;
  logic [php_pkg::ADDR_W-1:0]   addr_r, addr_nxt;
  logic [php_pkg::DATA_W-1:0]   wdata_r, wdata_nxt;
  logic [php_pkg::DATA_W-1:0]   rdata_r, rdata_nxt;
  logic                         ce_n_r, ce_n_nxt;
  logic                         wr_n_r, wr_n_nxt;
  logic                         rd_n_r, rd_n_nxt;
  logic                         oe_r, oe_nxt;
  logic                         done_r, done_nxt;
  logic                         take;
  logic                         rd_sample;

  // phase counts run down to one; a zero load also ends the phase, so the count never wraps
  function automatic logic cnt_last(input logic [3:0] cnt);
    return (cnt <= 4'h1);
  endfunction : cnt_last

  function automatic logic [3:0] cnt_dec(input logic [3:0] cnt);
    return cnt - 4'h1;
  endfunction : cnt_dec

  // a request is taken only in idle; anything raised during an access is dropped
  assign take      = (state_r == php_pkg::ST_IDLE) && i_req;
  // read data is taken on the last strobe-low cycle, before the strobe rises and the device lets go
  assign rd_sample = (state_r == php_pkg::ST_STROBE) && cnt_last(cnt_r) && !we_r;

  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    ce_n_nxt  = ce_n_r;
    wr_n_nxt  = wr_n_r;
    rd_n_nxt  = rd_n_r;
    oe_nxt    = oe_r;
    done_nxt  = 1'b0;
    case (state_r)
      php_pkg::ST_IDLE:
      begin
        if (take)
        begin
          // chip enable falls ahead of the strobe; transfers need it low
          ce_n_nxt  = 1'b0;
          // host drives data only for writes, never while a read strobe is low
          oe_nxt    = i_we;
          cnt_nxt   = php_pkg::SETUP_CYC;
          state_nxt = php_pkg::ST_SETUP;
        end
      end
      php_pkg::ST_SETUP:
      begin
        if (cnt_last(cnt_r))
        begin
          // falling strobe opens the cycle
          wr_n_nxt  = ~we_r;
          rd_n_nxt  = we_r;
          cnt_nxt   = php_pkg::STROBE_CYC;
          state_nxt = php_pkg::ST_STROBE;
        end
        else
        begin
          cnt_nxt = cnt_dec(cnt_r);
        end
      end
      php_pkg::ST_STROBE:
      begin
        if (cnt_last(cnt_r))
        begin
          // data held across the rising write edge, where the device latches
          wr_n_nxt  = 1'b1;
          rd_n_nxt  = 1'b1;
          cnt_nxt   = php_pkg::HOLD_CYC;
          state_nxt = php_pkg::ST_HOLD;
        end
        else
        begin
          cnt_nxt = cnt_dec(cnt_r);
        end
      end
      php_pkg::ST_HOLD:
      begin
        // chip enable rises after the strobe so the latch edge lands inside the enable
        if (cnt_last(cnt_r))
        begin
          ce_n_nxt  = 1'b1;
          oe_nxt    = 1'b0;
          state_nxt = php_pkg::ST_DONE;
        end
        else
        begin
          cnt_nxt = cnt_dec(cnt_r);
        end
      end
      php_pkg::ST_DONE:
      begin
        done_nxt  = 1'b1;
        state_nxt = php_pkg::ST_IDLE;
      end
      default:
      begin
        // an illegal state parks every pin at its idle level
        ce_n_nxt  = 1'b1;
        wr_n_nxt  = 1'b1;
        rd_n_nxt  = 1'b1;
        oe_nxt    = 1'b0;
        state_nxt = php_pkg::ST_IDLE;
      end
    endcase
  end

  // pins go idle at once; a reset in mid-write may still hand the device a latch edge
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state_r <= php_pkg::ST_IDLE;
      cnt_r   <= 4'h0;
      ce_n_r  <= 1'b1;
      wr_n_r  <= 1'b1;
      rd_n_r  <= 1'b1;
      oe_r    <= 1'b0;
      done_r  <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      ce_n_r  <= ce_n_nxt;
      wr_n_r  <= wr_n_nxt;
      rd_n_r  <= rd_n_nxt;
      oe_r    <= oe_nxt;
      done_r  <= done_nxt;
    end
  end

  // request fields are latched at the take, so i_addr and i_wdata may move once an access has begun
  always_comb
  begin
    we_nxt    = we_r;
    addr_nxt  = addr_r;
    wdata_nxt = wdata_r;
    rdata_nxt = rdata_r;
    if (take)
    begin
      we_nxt    = i_we;
      addr_nxt  = i_addr;
      wdata_nxt = i_wdata;
    end
    if (rd_sample)
    begin
      // sample before the strobe rises: device drive stops with it
      rdata_nxt = i_host_data_bus;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      we_r    <= 1'b0;
      addr_r  <= php_pkg::ADDR_RST;
      wdata_r <= php_pkg::DATA_RST;
      rdata_r <= php_pkg::DATA_RST;
    end
    else
    begin
      we_r    <= we_nxt;
      addr_r  <= addr_nxt;
      wdata_r <= wdata_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // every pin and data output comes straight from a flip-flop, so the device sees no glitch
  assign o_ready            = (state_r == php_pkg::ST_IDLE);
  assign o_done             = done_r;
  assign o_rdata            = rdata_r;
  assign o_addr             = addr_r;
  assign o_ce_n             = ce_n_r;
  assign o_wr_n             = wr_n_r;
  assign o_rd_n             = rd_n_r;
  assign o_host_data_bus    = wdata_r;
  assign o_host_data_bus_oe = oe_r;
endmodule : php_host
`default_nettype wire

// ### sim/php_host_props.sv
// Purpose: pin checks for the host port
// Assumes: one clock
// Notes: none
`timescale 1ns/100ps
`default_nettype none
module php_host_props (
  input wire logic       i_clk,
  input wire logic       i_resetn,
  input wire logic       o_done,
  input wire logic       o_ce_n,
  input wire logic       o_wr_n,
  input wire logic       o_rd_n,
  input wire logic [7:0] o_host_data_bus,
  input wire logic       o_host_data_bus_oe
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  wr_gated_a: assert property (!o_wr_n |-> !o_ce_n && o_host_data_bus_oe && o_rd_n)
    else $error("write gating");
  rd_gated_a: assert property (!o_rd_n |-> !o_ce_n && !o_host_data_bus_oe)
    else $error("read gating");
  wr_pulse_a: assert property ($fell(o_wr_n) |-> (!o_wr_n)[*3] ##1 o_wr_n && !o_ce_n && $stable(o_host_data_bus))
    else $error("write pulse");
  rd_pulse_a: assert property ($fell(o_rd_n) |-> (!o_rd_n)[*3] ##1 o_rd_n && !o_ce_n ##1 o_ce_n ##1 o_done)
    else $error("read pulse");
  ce_idle_a: assert property (o_ce_n |-> o_wr_n && o_rd_n && !o_host_data_bus_oe)
    else $error("idle strobes");
endmodule : php_host_props
`default_nettype wire

// ### sim/php_dev_model.sv
// Purpose: device side of the port
// Assumes: registers start at zero
// Notes: undriven bus shows inverse of last value, no pull-up
`timescale 1ns/100ps
`default_nettype none
module php_dev_model (
  input  wire logic       i_ce_n,
  input  wire logic       i_wr_n,
  input  wire logic       i_rd_n,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_d,
  input  wire logic       i_oe,
  output logic      [7:0] o_bus
);
  logic [7:0] mem [256];
  logic [7:0] last = 8'h00;
  wire logic  drv = !i_rd_n && !i_ce_n;
  initial foreach (mem[k]) mem[k] = 8'h00;
  always @(posedge i_wr_n) if (!i_ce_n) mem[i_addr] <= i_d;
  assign o_bus = i_oe ? i_d : drv ? mem[i_addr] : ~last;
  always @* if (i_oe || drv) last = o_bus;
endmodule : php_dev_model
`default_nettype wire

// ### sim/php_host_bench.sv
// Purpose: self-checking bench
// Assumes: 10 MHz clock
// Notes: random traffic from a shift register
`timescale 1ns/100ps
`default_nettype none
module php_host_bench;
  logic       clk = 0, rst_n = 0, req = 0, we = 0, rdy, done, ce_n, wr_n, rd_n, oe;
  logic [7:0] addr = 8'h00, wd = 8'h00, rdata, pa, dout, bus;
  logic [7:0] exp_r [256];
  logic [15:0] rnd = 16'h7c50;
  int         failures = 0, num_checks = 0;
  always #50 clk = ~clk;
  php_host DUT (.i_clk(clk), .i_resetn(rst_n), .i_req(req), .i_we(we), .i_addr(addr), .i_wdata(wd),
    .o_ready(rdy), .o_done(done), .o_rdata(rdata), .o_addr(pa), .o_ce_n(ce_n), .o_wr_n(wr_n), .o_rd_n(rd_n),
    .i_host_data_bus(bus), .o_host_data_bus(dout), .o_host_data_bus_oe(oe));
  php_dev_model dev (.i_ce_n(ce_n), .i_wr_n(wr_n), .i_rd_n(rd_n), .i_addr(pa), .i_d(dout), .i_oe(oe), .o_bus(bus));
  // edges from the take to o_done: every phase count, then the done cycle
  function automatic int exp_latency();
    return int'(php_pkg::SETUP_CYC) + int'(php_pkg::STROBE_CYC) + int'(php_pkg::HOLD_CYC) + 1;
  endfunction : exp_latency
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr_next
  task automatic check_data(input string what, input logic [7:0] e, input logic [7:0] s);
    num_checks++;
    if (s !== e)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, e, s);
    end
  endtask : check_data
  task automatic check_pin(input string what, input logic e, input logic s);
    num_checks++;
    if (s !== e)
    begin
      failures++;
      $display("wrong value %s expected %b seen %b", what, e, s);
    end
  endtask : check_pin
  task automatic check_count(input string what, input int e, input int s);
    num_checks++;
    if (s != e)
    begin
      failures++;
      $display("wrong value %s expected %0d seen %0d", what, e, s);
    end
  endtask : check_count
  task automatic end_of_test;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
    begin
      $display("DONE - PASS");
    end
    else
    begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test
  // next request rides on done, so accesses run back to back
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n = 0;
    we = w;
    addr = a;
    wd = d;
    req = 1;
    @(posedge clk);
    #1 req = 0;
    check_pin("ce_n busy", 1'b0, ce_n);
    check_pin("ready busy", 1'b0, rdy);
    while (done !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      #1 n++;
    end
    check_count("latency", exp_latency(), n);
    check_pin("ready done", 1'b1, rdy);
    check_pin("ce_n done", 1'b1, ce_n);
    if (w) exp_r[a] = d;
    else check_data("rdata", exp_r[a], rdata);
  endtask : access
  // reset between accesses must bring back the idle pins and the reset read data
  task automatic reset_pulse;
    rst_n = 0;
    @(posedge clk);
    @(posedge clk);
    #1 check_pin("ready reset", 1'b1, rdy);
    check_pin("ce_n reset", 1'b1, ce_n);
    check_pin("wr_n reset", 1'b1, wr_n);
    check_pin("rd_n reset", 1'b1, rd_n);
    check_data("rdata reset", php_pkg::DATA_RST, rdata);
    rst_n = 1;
  endtask : reset_pulse
  initial
  begin
    foreach (exp_r[k]) exp_r[k] = 8'h00;
    repeat (16) @(posedge clk);
    #1 rst_n = 1;
    access(1, 8'hff, 8'hff);
    access(0, 8'hff, 8'h00);
    reset_pulse();
    access(0, 8'h00, 8'h00);
    repeat (200)
    begin
      rnd = lfsr_next(rnd);
      access(rnd[0], {4'h0, rnd[4:1]}, rnd[15:8]);
    end
    end_of_test();
  end
  initial
  begin
    // twice the time that reset and every access should take, take edge included
    #(100 * 2 * (20 + 210 * (exp_latency() + 1)));
    failures++;
    end_of_test();
  end
endmodule : php_host_bench
bind php_host php_host_props u_props (.i_clk, .i_resetn, .o_done, .o_ce_n, .o_wr_n, .o_rd_n,
  .o_host_data_bus, .o_host_data_bus_oe);
`default_nettype wire
